// ===== inc/escr_pkg.sv
// Constants and types for the exception state and reset control block.
// Behaviour
// - Writing 1 to bit 31 pends the NMI; zero ignored; read shows pending.
// - Bit 30 write-one clears NMI pending; non-secure access RAZ/WI while routing secure.
// - With security, NMI handler reads set bit as 1 only if NMI reasserted meanwhile.
// - Bit 28 write-one pends deferred call; reads pending; nothing else pends it.
// - Bit 27 write-one removes deferred call pending; zero ignored.
// - Bit 26 write-one pends tick exception; reads its pending state.
// - Bit 25 write-one removes tick pending; reads unspecified (zero here).
// - Bit 23 shows a pending exception will be taken on debug exit.
// - Bit 22 shows any interrupt pending, excluding NMI and faults.
// - Field 20:12 shows top pending enabled exception number or zero.
// - Bit 11 is 0 with pre-empted actives, else 1.
// - Field 8:0 shows active exception number, zero in thread mode.
// - Deferred call set/clear banked per security state; others shared.
// - Key field reads 0xFA05; writes without key 0x5FA ignored.
// - Bit 15 shows data byte order, 1 for big-endian.
// - Bit 14 secure-only boost; RAZ/WI non-secure or without security.
// - Bit 13 resets 0; secure writes; non-secure reads; reads one without security.
// - Field 10:8 priority split point, banked between security states.
// - Bit 3 secure-only writable, warm-reset cleared, restricts reset request.
// - Bit 2 write-one requests system reset; RAZ/WI non-secure when restricted.
// - Bit 1 reads zero; software writes zero only.
package escr_pkg;
  localparam int unsigned ISR_NMI_SET = 31;
  localparam int unsigned ISR_NMI_CLR = 30;
  localparam int unsigned ISR_DC_SET = 28;
  localparam int unsigned ISR_DC_CLR = 27;
  localparam int unsigned ISR_TK_SET = 26;
  localparam int unsigned ISR_TK_CLR = 25;
  localparam int unsigned ISR_PREEMPT = 23;
  localparam int unsigned ISR_IRQ_WAIT = 22;
  localparam int unsigned ISR_TOP_LSB = 12;
  localparam int unsigned ISR_SINGLE = 11;
  localparam int unsigned ISR_CUR_LSB = 0;
  localparam int unsigned VEC_W = 9;
  localparam int unsigned AIR_KEY_LSB = 16;
  localparam int unsigned AIR_ENDIAN = 15;
  localparam int unsigned AIR_BOOST = 14;
  localparam int unsigned AIR_ROUTE = 13;
  localparam int unsigned AIR_SPLIT_LSB = 8;
  localparam int unsigned AIR_RST_SEC = 3;
  localparam int unsigned AIR_RST_REQ = 2;
  localparam int unsigned SPLIT_W = 3;
  localparam logic [15:0] KEY_READ = 16'hfa05;
  localparam logic [15:0] KEY_WRITE = 16'h05fa;
  localparam logic [2:0] SPLIT_RESET = 3'h0;
  typedef enum logic [0:0] {ESCR_SEL_ISR, ESCR_SEL_AIR} escr_sel_t;
endpackage : escr_pkg

// ===== rtl/escr_pend_bit.sv
`timescale 1ns/1ns
// One pending flag with write-one set and clear; hardware set wins over clear.
module escr_pend_bit
  import escr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic set_i,
  input wire logic clr_i,
  output logic pend_o
);
  logic pend_q;
  logic pend_d;

  always_comb begin
    pend_d = pend_q;
    if (clr_i) begin
      pend_d = 1'b0;
    end
    if (set_i) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  assign pend_o = pend_q;

  a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    set_i |=> pend_q) else $error("pending flag lost a set");
  a_clr_works: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clr_i && !set_i) |=> !pend_q) else $error("pending flag not cleared");
endmodule : escr_pend_bit

// ===== rtl/escr_sync2.sv
`timescale 1ns/1ns
// Two-flop synchroniser for a level from outside the clock domain.
module escr_sync2
  import escr_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : escr_sync2

// ===== rtl/escr_top.sv
`timescale 1ns/1ns
// Interrupt state and application reset control registers of the core.
module escr_top
  import escr_pkg::*;
#(
  parameter bit SECURITY_EXT = 1'b1,
  parameter bit BIG_ENDIAN = 1'b0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic warm_resetn,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire escr_sel_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_secure,
  output logic [31:0] reg_rdata,
  input wire logic nmi_in,
  input wire logic in_nmi_handler,
  input wire logic tick_event,
  input wire logic nmi_taken,
  input wire logic dc_taken,
  input wire logic tick_taken,
  input wire logic [VEC_W-1:0] active_num,
  input wire logic preempted_active,
  input wire logic irq_waiting,
  input wire logic [VEC_W-1:0] top_waiting,
  input wire logic debug_exit_pend,
  output logic nmi_pending,
  output logic dc_pending_s,
  output logic dc_pending_ns,
  output logic tick_pending,
  output logic secure_priority_boost,
  output logic fault_nmi_nonsecure_route,
  output logic [SPLIT_W-1:0] split_s,
  output logic [SPLIT_W-1:0] split_ns,
  output logic system_reset_request
);
  logic rst_meta_q;
  logic rst_n;
  logic nmi_s;
  logic nmi_prev_q;
  logic nmi_rise;
  logic wr_isr;
  logic wr_air;
  logic key_ok;
  logic nmi_ns_block;
  logic nmi_p;
  logic dcs_p;
  logic dcn_p;
  logic tk_p;
  logic nmi_re_q;
  logic nmi_re_d;
  logic boost_q;
  logic boost_d;
  logic route_q;
  logic route_d;
  logic [SPLIT_W-1:0] split_s_q;
  logic [SPLIT_W-1:0] split_s_d;
  logic [SPLIT_W-1:0] split_ns_q;
  logic [SPLIT_W-1:0] split_ns_d;
  logic rsec_q;
  logic rsec_d;
  logic rreq_q;
  logic rreq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic dc_set_s;
  logic dc_set_ns;
  logic dc_clr_s;
  logic dc_clr_ns;

  // Reset released through two flops so every register leaves reset on one edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  escr_sync2 #(.WIDTH(1)) u_nmi_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_i(nmi_in),
    .sync_o(nmi_s)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
    end
  end
  assign nmi_rise = nmi_s && !nmi_prev_q;

  assign wr_isr = reg_sel && reg_wr && (reg_addr == ESCR_SEL_ISR);
  assign key_ok = (reg_wdata[31:AIR_KEY_LSB] == KEY_WRITE);
  assign wr_air = reg_sel && reg_wr && (reg_addr == ESCR_SEL_AIR) && key_ok;
  // Non-secure side loses NMI clear while fault routing stays secure.
  assign nmi_ns_block = SECURITY_EXT && !reg_secure && !route_q;

  escr_pend_bit u_nmi (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(nmi_rise || (wr_isr && reg_wdata[ISR_NMI_SET])),
    .clr_i(nmi_taken || (wr_isr && reg_wdata[ISR_NMI_CLR] && !nmi_ns_block)),
    .pend_o(nmi_p)
  );

  // Without security support only the secure copy is used.
  assign dc_set_s = wr_isr && reg_wdata[ISR_DC_SET] && (reg_secure || !SECURITY_EXT);
  assign dc_set_ns = wr_isr && reg_wdata[ISR_DC_SET] && !reg_secure && SECURITY_EXT;
  assign dc_clr_s = wr_isr && reg_wdata[ISR_DC_CLR] && (reg_secure || !SECURITY_EXT);
  assign dc_clr_ns = wr_isr && reg_wdata[ISR_DC_CLR] && !reg_secure && SECURITY_EXT;

  escr_pend_bit u_dc_s (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(dc_set_s),
    .clr_i(dc_clr_s || (dc_taken && (reg_secure || !SECURITY_EXT))),
    .pend_o(dcs_p)
  );

  escr_pend_bit u_dc_ns (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(dc_set_ns),
    .clr_i(dc_clr_ns || (dc_taken && !reg_secure && SECURITY_EXT)),
    .pend_o(dcn_p)
  );

  escr_pend_bit u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set_i(tick_event || (wr_isr && reg_wdata[ISR_TK_SET])),
    .clr_i(tick_taken || (wr_isr && reg_wdata[ISR_TK_CLR])),
    .pend_o(tk_p)
  );

  // Tracks NMI reassertion while its handler runs; held clear while no NMI handler runs.
  always_comb begin
    nmi_re_d = nmi_re_q;
    if (!in_nmi_handler) begin
      nmi_re_d = 1'b0;
    end else if (nmi_rise) begin
      nmi_re_d = 1'b1;
    end
  end

  always_comb begin
    boost_d = boost_q;
    route_d = route_q;
    split_s_d = split_s_q;
    split_ns_d = split_ns_q;
    rsec_d = rsec_q;
    rreq_d = 1'b0;
    if (wr_air) begin
      if (SECURITY_EXT && reg_secure) begin
        boost_d = reg_wdata[AIR_BOOST];
        route_d = reg_wdata[AIR_ROUTE];
        rsec_d = reg_wdata[AIR_RST_SEC];
      end
      if (!SECURITY_EXT || reg_secure) begin
        split_s_d = reg_wdata[AIR_SPLIT_LSB +: SPLIT_W];
      end else begin
        split_ns_d = reg_wdata[AIR_SPLIT_LSB +: SPLIT_W];
      end
      if (!(SECURITY_EXT && rsec_q && !reg_secure)) begin
        rreq_d = reg_wdata[AIR_RST_REQ];
      end
    end
  end

  // Read mux; reserved and write-only bits stay zero; debug bit 23 shows debug_exit_pend.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == ESCR_SEL_ISR) begin
      if (SECURITY_EXT && in_nmi_handler) begin
        rdata_d[ISR_NMI_SET] = nmi_re_q;
      end else begin
        rdata_d[ISR_NMI_SET] = nmi_p;
      end
      rdata_d[ISR_DC_SET] = (SECURITY_EXT && !reg_secure) ? dcn_p : dcs_p;
      rdata_d[ISR_TK_SET] = tk_p;
      rdata_d[ISR_PREEMPT] = debug_exit_pend;
      rdata_d[ISR_IRQ_WAIT] = irq_waiting;
      rdata_d[ISR_TOP_LSB +: VEC_W] = top_waiting;
      rdata_d[ISR_SINGLE] = !preempted_active;
      rdata_d[ISR_CUR_LSB +: VEC_W] = active_num;
    end else begin
      rdata_d[31:AIR_KEY_LSB] = KEY_READ;
      rdata_d[AIR_ENDIAN] = BIG_ENDIAN;
      rdata_d[AIR_BOOST] = SECURITY_EXT && reg_secure && boost_q;
      rdata_d[AIR_ROUTE] = SECURITY_EXT ? route_q : 1'b1;
      rdata_d[AIR_SPLIT_LSB +: SPLIT_W] =
        (SECURITY_EXT && !reg_secure) ? split_ns_q : split_s_q;
      rdata_d[AIR_RST_SEC] = SECURITY_EXT && reg_secure && rsec_q;
      rdata_d[AIR_RST_REQ] = !(SECURITY_EXT && rsec_q && !reg_secure) && rreq_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_re_q <= 1'b0;
      boost_q <= 1'b0;
      route_q <= 1'b0;
      split_s_q <= SPLIT_RESET;
      split_ns_q <= SPLIT_RESET;
      rreq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      nmi_re_q <= nmi_re_d;
      boost_q <= boost_d;
      route_q <= route_d;
      split_s_q <= split_s_d;
      split_ns_q <= split_ns_d;
      rreq_q <= rreq_d;
      rdata_q <= rdata_d;
    end
  end

  // The secure-only restriction also falls back on a warm reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsec_q <= 1'b0;
    end else if (!warm_resetn) begin
      rsec_q <= 1'b0;
    end else begin
      rsec_q <= rsec_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign nmi_pending = nmi_p;
  assign dc_pending_s = dcs_p;
  assign dc_pending_ns = dcn_p;
  assign tick_pending = tk_p;
  assign secure_priority_boost = boost_q;
  assign fault_nmi_nonsecure_route = SECURITY_EXT ? route_q : 1'b1;
  assign split_s = split_s_q;
  assign split_ns = split_ns_q;
  assign system_reset_request = rreq_q;

  a_bad_key: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_sel && reg_wr && reg_addr == ESCR_SEL_AIR && !key_ok)
    |=> $stable(split_s_q) && $stable(split_ns_q) && !rreq_q)
    else $error("keyless write changed reset control state");
  a_key_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == ESCR_SEL_AIR) |=> reg_rdata[31:16] == 16'hfa05)
    else $error("key readback wrong");
  a_reset_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_air && reg_wdata[2] && reg_secure) |=> system_reset_request)
    else $error("reset request missed");
  a_reset_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (SECURITY_EXT && rsec_q && !reg_secure) |=> !system_reset_request)
    else $error("blocked reset request passed");
  a_boost_ns: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (SECURITY_EXT && !reg_secure) |-> boost_d == boost_q)
    else $error("non-secure wrote boost");
  a_tick_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_isr && reg_wdata[26]) |=> tick_pending)
    else $error("tick set lost");
  a_single_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == ESCR_SEL_ISR) |=> reg_rdata[11] == !$past(preempted_active))
    else $error("single active flag wrong");
  a_active_num: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == ESCR_SEL_ISR) |=> reg_rdata[8:0] == $past(active_num))
    else $error("active number wrong");
  // The key readback sets bit 29 of the reset control word, so each map is checked on its own.
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == ESCR_SEL_ISR) |=> reg_rdata[29] == 1'b0 && reg_rdata[24] == 1'b0 &&
    reg_rdata[21] == 1'b0 && reg_rdata[10:9] == 2'h0)
    else $error("reserved bit reads nonzero");
  a_air_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_addr == ESCR_SEL_AIR) |=> reg_rdata[12:11] == 2'h0 && reg_rdata[7:4] == 4'h0 &&
    reg_rdata[1:0] == 2'h0)
    else $error("reserved reset control bit reads nonzero");
endmodule : escr_top

// ===== sim/test_escr_top.sv
`timescale 1ns/1ns
// Self-checking bench for the interrupt state and reset control registers.
module test_escr_top;
  import escr_pkg::*;
  logic ref_clk, resetn, warm_resetn, reg_sel, reg_wr, reg_secure;
  escr_sel_t reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic nmi_in, in_nmi_handler, tick_event, nmi_taken, dc_taken, tick_taken;
  logic [VEC_W-1:0] active_num, top_waiting;
  logic preempted_active, irq_waiting, debug_exit_pend;
  logic nmi_pending, dc_pending_s, dc_pending_ns, tick_pending;
  logic secure_priority_boost, fault_nmi_nonsecure_route, system_reset_request;
  logic [SPLIT_W-1:0] split_s, split_ns;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  escr_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .warm_resetn(warm_resetn),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_secure(reg_secure), .reg_rdata(reg_rdata), .nmi_in(nmi_in),
    .in_nmi_handler(in_nmi_handler), .tick_event(tick_event), .nmi_taken(nmi_taken),
    .dc_taken(dc_taken), .tick_taken(tick_taken), .active_num(active_num),
    .preempted_active(preempted_active), .irq_waiting(irq_waiting),
    .top_waiting(top_waiting), .debug_exit_pend(debug_exit_pend),
    .nmi_pending(nmi_pending), .dc_pending_s(dc_pending_s), .dc_pending_ns(dc_pending_ns),
    .tick_pending(tick_pending), .secure_priority_boost(secure_priority_boost),
    .fault_nmi_nonsecure_route(fault_nmi_nonsecure_route), .split_s(split_s),
    .split_ns(split_ns), .system_reset_request(system_reset_request));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // A hang anywhere ends the run as a failure rather than stalling the simulator.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input escr_sel_t a, input logic [31:0] d, input logic sec);
    @(negedge ref_clk);
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_secure = sec;
    @(negedge ref_clk);
    reg_sel = 1'b0;
    reg_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken one full cycle after the address.
  task rd(input escr_sel_t a, input logic sec);
    @(negedge ref_clk);
    reg_sel = 1'b1;
    reg_addr = a;
    reg_secure = sec;
    @(negedge ref_clk);
    rv = reg_rdata;
    reg_sel = 1'b0;
  endtask : rd

  // The request is a single-cycle pulse; a window of four cycles catches it once.
  task cnt;
    n = 0;
    repeat (4) begin
      if (system_reset_request === 1'b1) n++;
      @(negedge ref_clk);
    end
  endtask : cnt

  task t_nmi;
    wr(ESCR_SEL_ISR, 32'h8000_0000, 1'b1);
    wr(ESCR_SEL_ISR, 32'h0000_0000, 1'b1);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv & 32'h8000_0000, 32'h8000_0000);
    wr(ESCR_SEL_ISR, 32'h4000_0000, 1'b0);
    chk({31'h0, nmi_pending}, 32'h1);
    wr(ESCR_SEL_ISR, 32'h4000_0000, 1'b1);
    chk({31'h0, nmi_pending}, 32'h0);
    in_nmi_handler = 1'b1;
    wr(ESCR_SEL_ISR, 32'h8000_0000, 1'b1);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv & 32'h8000_0000, 32'h0);
    nmi_in = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv & 32'h8000_0000, 32'h8000_0000);
    nmi_in = 1'b0;
    in_nmi_handler = 1'b0;
    nmi_taken = 1'b1;
    @(negedge ref_clk);
    nmi_taken = 1'b0;
    @(negedge ref_clk);
    chk({31'h0, nmi_pending}, 32'h0);
  endtask : t_nmi

  task t_pend;
    wr(ESCR_SEL_ISR, 32'h1000_0000, 1'b1);
    chk({30'h0, dc_pending_ns, dc_pending_s}, 32'h1);
    rd(ESCR_SEL_ISR, 1'b0);
    chk(rv & 32'h1000_0000, 32'h0);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv & 32'h1000_0000, 32'h1000_0000);
    wr(ESCR_SEL_ISR, 32'h0800_0000, 1'b0);
    chk({31'h0, dc_pending_s}, 32'h1);
    wr(ESCR_SEL_ISR, 32'h0800_0000, 1'b1);
    chk({31'h0, dc_pending_s}, 32'h0);
    wr(ESCR_SEL_ISR, 32'h1000_0000, 1'b1);
    dc_taken = 1'b1;
    @(negedge ref_clk);
    dc_taken = 1'b0;
    chk({30'h0, dc_pending_ns, dc_pending_s}, 32'h0);
    wr(ESCR_SEL_ISR, 32'h0400_0000, 1'b1);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv & 32'h0600_0000, 32'h0400_0000);
    wr(ESCR_SEL_ISR, 32'h0200_0000, 1'b0);
    chk({31'h0, tick_pending}, 32'h0);
    tick_event = 1'b1;
    @(negedge ref_clk);
    tick_event = 1'b0;
    @(negedge ref_clk);
    chk({31'h0, tick_pending}, 32'h1);
    tick_taken = 1'b1;
    @(negedge ref_clk);
    tick_taken = 1'b0;
    @(negedge ref_clk);
    chk({31'h0, tick_pending}, 32'h0);
  endtask : t_pend

  task t_status;
    active_num = 9'h013;
    top_waiting = 9'h02f;
    irq_waiting = 1'b1;
    debug_exit_pend = 1'b1;
    preempted_active = 1'b1;
    rd(ESCR_SEL_ISR, 1'b0);
    chk(rv, 32'h00c2_f013);
    preempted_active = 1'b0;
    irq_waiting = 1'b0;
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv, 32'h0082_f813);
    active_num = 9'h000;
    top_waiting = 9'h000;
    debug_exit_pend = 1'b0;
  endtask : t_status

  task t_air;
    rd(ESCR_SEL_AIR, 1'b1);
    chk(rv, 32'hfa05_0000);
    wr(ESCR_SEL_AIR, 32'h1234_0500, 1'b1);
    rd(ESCR_SEL_AIR, 1'b1);
    chk(rv, 32'hfa05_0000);
    wr(ESCR_SEL_AIR, 32'h05fa_7df8, 1'b1);
    rd(ESCR_SEL_AIR, 1'b1);
    chk(rv, 32'hfa05_6508);
    chk({24'h0, secure_priority_boost, fault_nmi_nonsecure_route, split_s, split_ns},
      32'he8);
    rd(ESCR_SEL_AIR, 1'b0);
    chk(rv, 32'hfa05_2000);
    wr(ESCR_SEL_AIR, 32'h05fa_0304, 1'b0);
    cnt();
    chk(32'(n), 32'h0);
    chk({24'h0, secure_priority_boost, fault_nmi_nonsecure_route, split_s, split_ns},
      32'heb);
    wr(ESCR_SEL_ISR, 32'h8000_0000, 1'b1);
    wr(ESCR_SEL_ISR, 32'h4000_0000, 1'b0);
    chk({31'h0, nmi_pending}, 32'h0);
    warm_resetn = 1'b0;
    @(negedge ref_clk);
    warm_resetn = 1'b1;
    rd(ESCR_SEL_AIR, 1'b1);
    chk(rv, 32'hfa05_6500);
    wr(ESCR_SEL_AIR, 32'h05fa_6504, 1'b0);
    cnt();
    chk(32'(n), 32'h1);
    wr(ESCR_SEL_AIR, 32'h05fa_0504, 1'b1);
    cnt();
    chk(32'(n), 32'h1);
    rd(ESCR_SEL_AIR, 1'b1);
    chk(rv, 32'hfa05_0500);
  endtask : t_air

  initial begin
    {resetn, reg_sel, reg_wr, reg_secure, nmi_in, in_nmi_handler} = '0;
    {tick_event, nmi_taken, dc_taken, tick_taken, preempted_active} = '0;
    {irq_waiting, debug_exit_pend} = '0;
    warm_resetn = 1'b1;
    reg_addr = ESCR_SEL_ISR;
    reg_wdata = 32'h0;
    active_num = 9'h000;
    top_waiting = 9'h000;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    rd(ESCR_SEL_ISR, 1'b1);
    chk(rv, 32'h0000_0800);
    t_nmi();
    t_pend();
    t_status();
    t_air();
    wrap_up();
  end
endmodule : test_escr_top
